// file: pkg/css_pkg.sv
package css_pkg;

  // Clock period of clk_sys.
  localparam int CLK_NS = 40;

  // Sequence unit T, stepped in half units.
  localparam int T_NS       = 25000;
  localparam int HALF_T_CYC = T_NS / 2 / CLK_NS;

  // Activation steps, in half-T ticks from t0 (t1 is one tick after t0).
  localparam logic [4:0] STEP_T1     = 5'h01;
  localparam logic [4:0] STEP_SUPPLY = 5'h04;
  localparam logic [4:0] STEP_IO     = 5'h09;
  localparam logic [4:0] STEP_RST    = 5'h0f;

  // Deactivation steps, in half-T ticks from t10.
  localparam logic [4:0] DSTEP_CLK  = 5'h01;
  localparam logic [4:0] DSTEP_IO   = 5'h02;
  localparam logic [4:0] DSTEP_VCC  = 5'h03;
  localparam logic [4:0] DSTEP_DONE = 5'h04;

  // Least delay from I/O release to card clock start.
  localparam int IO_TO_CLK_NS  = 200;
  localparam int IO_TO_CLK_CYC = (IO_TO_CLK_NS + CLK_NS - 1) / CLK_NS;

  // Presence debounce and stop-mode wake delay.
  localparam int DEBOUNCE_MS  = 8;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000000 / CLK_NS;
  localparam int POWERUP_US   = 220;
  localparam int POWERUP_CYC  = POWERUP_US * 1000 / CLK_NS;

  // Synchroniser reset image: session request idle high, every other pin low.
  // Reset must never fake the stop pattern, or every reset would pass through stop and wake.
  localparam logic [10:0] SYNC_INIT = 11'h400;

  typedef enum logic [2:0] {
    CSS_IDLE,
    CSS_ACT,
    CSS_ACTIVE,
    CSS_DEACT,
    CSS_STOP,
    CSS_WAKE
  } css_state_t;

  typedef enum logic [1:0] {
    CSS_VCC_3V,
    CSS_VCC_5V,
    CSS_VCC_1V8
  } css_vsel_t;

  // Analog monitor flags, high when the fault is present.
  typedef struct packed {
    logic supply_short;
    logic host_supply_drop;
    logic generator_range;
    logic overheat;
  } css_faults_t;

  // Card contact controls.
  typedef struct packed {
    logic supply_enable;
    logic io_release;
    logic card_reset;
    logic clock_enable;
    logic grounded;
  } css_contacts_t;

endpackage : css_pkg

// file: verif/css_host_model.sv
`timescale 1ns/1ns
module css_host_model
  import css_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic          start,
  input  wire logic          applied_clk,
  input  wire css_contacts_t contacts,
  output logic               session_request_n,
  output logic               host_card_reset
);
  logic [11:0] wait_cnt;

  // The host counts from I/O release: 20 cycles lies inside t3..t5, 2000 lies past t5.
  always_ff @(posedge clk_sys)
  begin
    if (srst || !start)
    begin
      session_request_n <= 1'b1;
      host_card_reset   <= 1'b0;
      wait_cnt          <= 12'h000;
    end
    else if (session_request_n)
    begin
      host_card_reset   <= applied_clk;
      session_request_n <= (host_card_reset != applied_clk);
    end
    else if (contacts.io_release)
    begin
      wait_cnt <= (wait_cnt == 12'hfff) ? wait_cnt : wait_cnt + 12'h001;
      if (applied_clk && wait_cnt == 12'h014)
        host_card_reset <= 1'b0;
      if (wait_cnt == 12'h7d0)
        host_card_reset <= 1'b1;
    end
  end
endmodule : css_host_model

// file: verif/testbench.sv
`timescale 1ns/1ns
module testbench
  import css_pkg::*;
;
  typedef struct packed {logic [11:0] mask; logic [11:0] val;} css_note_t;

  logic          clk_sys = 1'b0;
  logic          srst = 1'b1;
  logic          start = 1'b0;
  logic          applied_clk = 1'b0;
  logic          low_voltage_select = 1'b0;
  logic          high_voltage_select = 1'b0;
  logic          slot_select = 1'b0;
  logic          card_detect_a = 1'b0;
  logic          card_detect_b = 1'b0;
  logic          probe = 1'b0;
  logic          r;
  css_faults_t   analog_faults = '0;
  wire logic     session_request_n;
  wire logic     host_card_reset;
  css_contacts_t contacts;
  css_vsel_t     supply_select;
  logic          osc_high;
  logic          analog_enable;
  logic          power_on_reset_pulse;
  logic          slot_status;
  logic          other_slot_presence_n;
  logic          active_slot_b;
  int            fails = 0;
  int            total_checks = 0;
  int            cyc = 0;
  int            por_cnt = 0;
  int            t_rise [12];
  int            t_fall [12];
  logic [11:0]   obs_q = '0;
  css_note_t     notes [$];
  css_note_t     note;
  logic [1:0]    vtab [3] = '{2'b01, 2'b00, 2'b10};
  css_vsel_t     etab [3] = '{CSS_VCC_5V, CSS_VCC_3V, CSS_VCC_1V8};
  wire logic [11:0] obs = {contacts, supply_select, osc_high, analog_enable, slot_status,
                           other_slot_presence_n, active_slot_b};

  always #20 clk_sys = ~clk_sys;

  css_host_model css_host_model_inst (.clk_sys(clk_sys), .srst(srst), .start(start),
    .applied_clk(applied_clk), .contacts(contacts), .session_request_n(session_request_n),
    .host_card_reset(host_card_reset));

  css_sequencer #(.DEB_CYC(20), .PUP_CYC(10)) css_sequencer_inst (.clk_sys(clk_sys), .srst(srst),
    .session_request_n(session_request_n), .host_card_reset(host_card_reset),
    .low_voltage_select(low_voltage_select), .high_voltage_select(high_voltage_select),
    .slot_select(slot_select), .card_detect_a(card_detect_a), .card_detect_b(card_detect_b),
    .analog_faults(analog_faults), .contacts(contacts), .supply_select(supply_select),
    .active_slot_b(active_slot_b), .osc_high(osc_high), .analog_enable(analog_enable),
    .power_on_reset_pulse(power_on_reset_pulse), .slot_status(slot_status),
    .other_slot_presence_n(other_slot_presence_n));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task win(input int d, input int lo, input int hi);
    check({15'h0000, d >= lo && d <= hi}, 16'h0001);
  endtask : win

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // Notes an expectation; the watcher compares it on the following edge.
  task expect_obs(input logic [11:0] mask, input logic [11:0] val);
    @(posedge clk_sys);
    notes.push_back('{mask, val});
    probe <= 1'b1;
    @(posedge clk_sys);
    probe <= 1'b0;
  endtask : expect_obs

  // Sampled on the falling edge so that the last rising edge's updates have landed.
  task wait_bit(input int idx, input logic lvl);
    int n;
    n = 0;
    while (obs[idx] !== lvl && n < 9000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check({15'h0000, obs[idx]}, {15'h0000, lvl});
    // Two rising edges let the edge-time recorder store this change and put stimulus back on the rising edge.
    repeat (2) @(posedge clk_sys);
  endtask : wait_bit

  task final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // The watcher pops the oldest note whenever a probe strobe is seen.
  always @(posedge clk_sys)
  begin
    if (probe === 1'b1)
    begin
      note = notes.pop_front();
      check({4'h0, obs & note.mask}, {4'h0, note.val});
    end
  end

  // Edge times of every watched output, so sequence spacing is measured in cycles.
  always @(posedge clk_sys)
  begin
    cyc   <= cyc + 1;
    obs_q <= obs;
    if (power_on_reset_pulse === 1'b1)
      por_cnt <= por_cnt + 1;
    for (int i = 0; i < 12; i++)
    begin
      if (obs[i] === 1'b1 && obs_q[i] === 1'b0)
        t_rise[i] <= cyc;
      if (obs[i] === 1'b0 && obs_q[i] === 1'b1)
        t_fall[i] <= cyc;
    end
  end

  // A hung wait is cut short well beyond the expected run of about 16000 cycles.
  initial
  begin
    #2400000;
    fails++;
    final_report();
  end

  initial
  begin
    void'($urandom(57334));
    tick(5);
    srst <= 1'b0;
    tick(4);
    expect_obs(12'hffe, 12'h088);
    for (int i = 0; i < 3; i++)
    begin
      {low_voltage_select, high_voltage_select} <= vtab[i];
      tick(4);
      expect_obs(12'h060, {5'h00, etab[i], 5'h00});
    end
    $display("test supply select done");
    r = 1'($urandom_range(1, 0));
    card_detect_a <= 1'b1;
    card_detect_b <= r;
    tick(8);
    expect_obs(12'h004, 12'h000);
    tick(30);
    expect_obs(12'h006, {9'h000, 1'b1, r, 1'b0});
    slot_select <= 1'b1;
    tick(5);
    expect_obs(12'h007, {9'h000, r, 2'b11});
    slot_select <= 1'b0;
    card_detect_b <= 1'b1;
    tick(30);
    analog_faults.host_supply_drop <= 1'b1;
    tick(6);
    analog_faults <= '0;
    check(16'(por_cnt), 16'h0001);
    expect_obs(12'h004, 12'h004);
    $display("test presence done");
    start <= 1'b1;
    wait_bit(9, 1'b1);
    expect_obs(12'hf64, 12'hf44);
    win(t_rise[11] - t_rise[4], 1, 313);
    win(t_rise[10] - t_rise[11], 2490, 2500);
    win(t_rise[8] - t_rise[10], 5, 8);
    win(t_rise[9] - t_rise[10], 1999, 2010);
    start <= 1'b0;
    tick(3);
    high_voltage_select <= 1'b1;
    wait_bit(3, 1'b0);
    win(t_fall[8] - t_fall[9], 1, 313);
    win(t_fall[10] - t_fall[8], 311, 313);
    win(t_fall[11] - t_fall[10], 311, 313);
    win(t_fall[3] - t_fall[11], 311, 316);
    $display("test session done");
    tick(1);
    card_detect_a <= 1'b0;
    tick(4);
    expect_obs(12'h004, 12'h000);
    card_detect_a <= 1'b1;
    tick(4);
    expect_obs(12'h004, 12'h004);
    high_voltage_select <= 1'b0;
    tick(20);
    expect_obs(12'h004, 12'h000);
    tick(30);
    expect_obs(12'h004, 12'h004);
    $display("test stop mode done");
    low_voltage_select <= 1'b0;
    applied_clk <= 1'b1;
    start <= 1'b1;
    wait_bit(8, 1'b1);
    win(t_rise[8] - t_rise[10], 20, 30);
    wait_bit(9, 1'b1);
    expect_obs(12'h100, 12'h100);
    analog_faults <= css_faults_t'(4'h1 << $urandom_range(3, 0));
    tick(3);
    expect_obs(12'h004, 12'h000);
    wait_bit(7, 1'b1);
    tick(1);
    analog_faults <= '0;
    expect_obs(12'hf94, 12'h080);
    start <= 1'b0;
    applied_clk <= 1'b0;
    tick(6);
    expect_obs(12'h004, 12'h004);
    $display("test fault done");
    start <= 1'b1;
    wait_bit(10, 1'b1);
    tick(1);
    card_detect_a <= 1'b0;
    tick(4);
    expect_obs(12'h004, 12'h000);
    wait_bit(7, 1'b1);
    tick(1);
    start <= 1'b0;
    tick(6);
    expect_obs(12'h004, 12'h000);
    $display("test extraction done");
    final_report();
  end
endmodule : testbench

// file: verilog/css_debounce.sv
`timescale 1ns/1ns
module css_debounce
  import css_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC
)
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic detect,
  input  wire logic restart,
  output logic      present
);

  localparam int CW = $clog2(DEB_CYC + 1);

  logic [CW-1:0] cnt;

  // A delay below two cycles leaves the counter nothing to count.
  if (DEB_CYC < 2)
  begin : g_bad_delay
    $error("css_debounce: DEB_CYC must be at least 2");
  end

  // Insertion must hold steady for the whole delay; removal drops at once.
  always_ff @(posedge clk_sys)
  begin
    if (srst || restart || !detect)
    begin
      cnt     <= '0;
      present <= 1'b0;
    end
    else if (!present)
    begin
      if (cnt == CW'(DEB_CYC - 1))
        present <= 1'b1;
      else
        cnt <= cnt + CW'(1);
    end
  end

  a_removal_fast: assert property (@(posedge clk_sys) disable iff (srst) !detect |=> !present)
    else $error("presence stayed up after removal");

  a_insert_delay: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(present) |-> $past(cnt) == CW'(DEB_CYC - 1))
    else $error("presence rose before the debounce delay");

endmodule : css_debounce

// file: verilog/css_sequencer.sv
`timescale 1ns/1ns
// Behaviour
// - Session starts on request low with card present.
// - Sequences timed in T of 64 oscillator periods.
// - Fast oscillator at t0, supply up by t1+1.5T.
// - Card I/O held low until t1+4T.
// - Card reset low until t1+7T, then copies host.
// - Applied clock starts when host reset falls.
// - After t5 host reset ignored for clock.
// - Reset low at request: clock at t3+200ns.
// - Deactivation order: reset, clock, I/O, supply.
// - After deactivation ground contacts, slow oscillator.
// - Session faults drop status and force deactivation.
// - Outside session status shows presence; drop pulses reset.
// - Status returns high after fault if card present.
// - Insertion debounced 8ms before status rises.
// - Removal drops status immediately, starts deactivation.
// - Stop mode on three pins high when inactive.
// - Stop disables analog; status follows detect directly.
// - Stop exit holds status low for 220us+8ms.
// - Running deactivation completes before stop entry.
// - Low-voltage select wins; else 5V or 3V.
// - Outputs report selected and other slot presence.
// - Slot select low is slot A, high slot B.
module css_sequencer
  import css_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int PUP_CYC = POWERUP_CYC
)
(
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic          session_request_n,
  input  wire logic          host_card_reset,
  input  wire logic          low_voltage_select,
  input  wire logic          high_voltage_select,
  input  wire logic          slot_select,
  input  wire logic          card_detect_a,
  input  wire logic          card_detect_b,
  input  wire css_faults_t   analog_faults,
  output css_contacts_t      contacts,
  output css_vsel_t          supply_select,
  output logic               active_slot_b,
  output logic               osc_high,
  output logic               analog_enable,
  output logic               power_on_reset_pulse,
  output logic               slot_status,
  output logic               other_slot_presence_n
);

  localparam int HW = $clog2(HALF_T_CYC);
  localparam int WW = $clog2(PUP_CYC + 1);

  css_state_t    state;
  logic [4:0]    step;
  logic [HW-1:0] hcnt;
  logic          tick;
  logic [WW-1:0] wcnt;
  logic          clk_mode;
  logic          fault;
  logic          rst_prev;
  logic          drop_prev;
  logic [10:0]   pins_s;
  logic          req_n_s;
  logic          host_card_reset_s;
  logic          lv_s;
  logic          hv_s;
  logic          sel_s;
  logic [1:0]    det_s;
  css_faults_t   flt_s;
  logic [1:0]    deb;
  logic          sel_det;
  logic          sel_deb;
  logic          other_deb;
  logic          stop_pins;
  logic          in_session;
  logic          fault_any;

  if (HALF_T_CYC < 2 || PUP_CYC < 2 || IO_TO_CLK_CYC >= HALF_T_CYC)
  begin : g_bad_timing
    $error("css_sequencer: timing constants cannot be served");
  end

  // Every pin crosses two flip-flops before use.
  css_sync #(
    .WIDTH (11),
    .INIT  (SYNC_INIT)
  ) u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .pin      ({session_request_n, low_voltage_select, high_voltage_select, host_card_reset,
                slot_select, card_detect_b, card_detect_a, analog_faults}),
    .pin_sync (pins_s)
  );

  assign req_n_s = pins_s[10];
  assign lv_s    = pins_s[9];
  assign hv_s    = pins_s[8];
  assign host_card_reset_s = pins_s[7];
  assign sel_s   = pins_s[6];
  assign det_s   = pins_s[5:4];
  assign flt_s   = pins_s[3:0];

  // One debouncer per slot; both held low while stopped or waking.
  for (genvar g = 0; g < 2; g++)
  begin : g_deb
    css_debounce #(
      .DEB_CYC (DEB_CYC)
    ) u_deb (
      .clk_sys (clk_sys),
      .srst    (srst),
      .detect  (det_s[g]),
      .restart (state == CSS_STOP || state == CSS_WAKE),
      .present (deb[g])
    );
  end

  // Slot routing: low selects slot A.
  assign sel_det    = sel_s ? det_s[1] : det_s[0];
  assign sel_deb    = sel_s ? deb[1] : deb[0];
  assign other_deb  = sel_s ? deb[0] : deb[1];
  assign stop_pins  = req_n_s && lv_s && hv_s;
  assign in_session = state == CSS_ACT || state == CSS_ACTIVE;
  // All fault flags and card removal only count during activation and the active state.
  assign fault_any  = in_session && (!sel_det || flt_s.supply_short || flt_s.host_supply_drop ||
                                     flt_s.generator_range || flt_s.overheat);

  // Half-T tick generator, free-running from reset and not restarted on state changes.
  always_ff @(posedge clk_sys)
  begin
    if (srst || tick)
      hcnt <= '0;
    else
      hcnt <= hcnt + HW'(1);
  end
  assign tick = hcnt == HW'(HALF_T_CYC - 1);

  // Main sequence.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state    <= CSS_IDLE;
      step     <= '0;
      wcnt     <= '0;
      clk_mode <= 1'b0;
    end
    else
    begin
      case (state)
        CSS_IDLE:
        begin
          step <= '0;
          if (stop_pins)
            state <= CSS_STOP;
          else if (!req_n_s && sel_deb && !fault)
          begin
            state    <= CSS_ACT;
            clk_mode <= host_card_reset_s;
          end
        end
        CSS_ACT:
        begin
          if (fault_any || req_n_s)
          begin
            state <= CSS_DEACT;
            step  <= '0;
          end
          else if (tick)
          begin
            step <= step + 5'h01;
            if (step == STEP_RST - 5'h01)
              state <= CSS_ACTIVE;
          end
        end
        CSS_ACTIVE:
        begin
          step <= '0;
          if (fault_any || req_n_s)
            state <= CSS_DEACT;
        end
        CSS_DEACT:
        begin
          if (tick)
          begin
            step <= step + 5'h01;
            if (step == DSTEP_DONE - 5'h01)
              state <= stop_pins ? CSS_STOP : CSS_IDLE;
          end
        end
        CSS_STOP:
        begin
          wcnt <= '0;
          if (!stop_pins)
            state <= CSS_WAKE;
        end
        CSS_WAKE:
        begin
          wcnt <= wcnt + WW'(1);
          if (wcnt == WW'(PUP_CYC - 1))
            state <= CSS_IDLE;
        end
        default:
          state <= CSS_IDLE;
      endcase
    end
  end

  // Fault is sticky until the host withdraws its request.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      fault <= 1'b0;
    else if (fault_any)
      fault <= 1'b1;
    else if (req_n_s && (state == CSS_IDLE || state == CSS_STOP))
      fault <= 1'b0;
  end

  // Contact drive, one cycle behind the state it decodes.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      contacts <= '{supply_enable: 1'b0, io_release: 1'b0, card_reset: 1'b0, clock_enable: 1'b0, grounded: 1'b1};
      rst_prev <= 1'b0;
    end
    else
    begin
      rst_prev <= host_card_reset_s;
      case (state)
        CSS_ACT:
        begin
          contacts.grounded      <= 1'b0;
          contacts.supply_enable <= step >= STEP_T1;
          contacts.io_release    <= step >= STEP_IO;
          contacts.card_reset    <= 1'b0;
          if (step >= STEP_IO && !clk_mode && (step > STEP_IO || hcnt >= HW'(IO_TO_CLK_CYC)))
            contacts.clock_enable <= 1'b1;
          else if (step >= STEP_IO && clk_mode && rst_prev && !host_card_reset_s)
            contacts.clock_enable <= 1'b1;
        end
        CSS_ACTIVE:
        begin
          contacts.card_reset <= host_card_reset_s;
        end
        CSS_DEACT:
        begin
          contacts.card_reset <= 1'b0;
          if (step >= DSTEP_CLK)
            contacts.clock_enable <= 1'b0;
          if (step >= DSTEP_IO)
            contacts.io_release <= 1'b0;
          if (step >= DSTEP_VCC)
            contacts.supply_enable <= 1'b0;
        end
        default:
        begin
          contacts <= '{supply_enable: 1'b0, io_release: 1'b0, card_reset: 1'b0, clock_enable: 1'b0,
                        grounded: 1'b1};
        end
      endcase
    end
  end

  // Status outputs, supply selection and housekeeping.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      slot_status           <= 1'b0;
      other_slot_presence_n <= 1'b0;
      supply_select         <= CSS_VCC_3V;
      active_slot_b         <= 1'b0;
      osc_high              <= 1'b0;
      analog_enable         <= 1'b1;
      power_on_reset_pulse  <= 1'b0;
      drop_prev             <= 1'b0;
    end
    else
    begin
      drop_prev             <= flt_s.host_supply_drop;
      active_slot_b         <= sel_s;
      other_slot_presence_n <= other_deb;
      supply_select         <= lv_s ? CSS_VCC_1V8 : (hv_s ? CSS_VCC_5V : CSS_VCC_3V);
      osc_high              <= state == CSS_ACT || state == CSS_ACTIVE || state == CSS_DEACT;
      analog_enable         <= state != CSS_STOP;
      // Outside a session a supply drop only pulses the internal reset.
      power_on_reset_pulse  <= !in_session && flt_s.host_supply_drop && !drop_prev;
      if (fault || fault_any)
        slot_status <= 1'b0;
      else if (state == CSS_STOP)
        slot_status <= sel_det;
      else if (state == CSS_WAKE)
        slot_status <= 1'b0;
      else
        slot_status <= sel_deb;
    end
  end

  a_io_release_time: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(contacts.io_release) |-> $past(state) == CSS_ACT && $past(step) == STEP_IO)
    else $error("card I/O released at the wrong step");

  a_reset_hold_low: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(contacts.card_reset) |-> $past(state) == CSS_ACTIVE && $past(host_card_reset_s))
    else $error("card reset rose before t5 or without host reset");

  a_deact_order: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(contacts.supply_enable) |-> !contacts.clock_enable && !contacts.io_release && !contacts.card_reset)
    else $error("supply fell before reset, clock and I/O");

  a_fault_drops: assert property (@(posedge clk_sys) disable iff (srst)
    fault_any |=> !slot_status ##1 state == CSS_DEACT)
    else $error("fault did not drop status and deactivate");

  a_stop_only_idle: assert property (@(posedge clk_sys) disable iff (srst)
    state == CSS_STOP && $past(state) != CSS_STOP |-> $past(state) inside {CSS_IDLE, CSS_DEACT})
    else $error("stop mode entered from an active state");

  a_stop_follows: assert property (@(posedge clk_sys) disable iff (srst)
    state == CSS_STOP && $past(state) == CSS_STOP && !fault |=> slot_status == $past(sel_det))
    else $error("status does not follow detect in stop mode");

  a_wake_holds: assert property (@(posedge clk_sys) disable iff (srst)
    state == CSS_STOP ##1 state == CSS_WAKE |=> !slot_status [*8])
    else $error("status released during stop wake delay");

  a_vsel_priority: assert property (@(posedge clk_sys) disable iff (srst)
    lv_s ##1 1'b1 |-> supply_select == CSS_VCC_1V8)
    else $error("low-voltage select did not take priority");

  a_clock_after_io: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(contacts.clock_enable) |-> contacts.io_release && $past(step) >= STEP_IO)
    else $error("card clock started before I/O release");
endmodule : css_sequencer

// file: verilog/css_sync.sv
`timescale 1ns/1ns
module css_sync
  import css_pkg::*;
#(
  parameter int          WIDTH = 11,
  parameter logic [10:0] INIT  = SYNC_INIT
)
(
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta;

  // The reset image holds eleven bits, so no wider bank can be served.
  if (WIDTH < 1 || WIDTH > 11)
  begin : g_bad_width
    $error("css_sync: WIDTH must lie between 1 and 11");
  end

  // Two stages; the first is read by the second only.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta     <= INIT[WIDTH-1:0];
      pin_sync <= INIT[WIDTH-1:0];
    end
    else
    begin
      meta     <= pin;
      pin_sync <= meta;
    end
  end

endmodule : css_sync
